// [sphc_pkg.sv]
// Constants, types and register map of the step positioning and homing block.
// Assumes one 100 MHz clock and a word-wide register port.
package sphc_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam logic [7:0]  OFS_CMD         = 8'h00;
	localparam logic [7:0]  OFS_SEEK_FREQ   = 8'h01;
	localparam logic [7:0]  OFS_SEEK_DIR    = 8'h02;
	localparam logic [7:0]  OFS_TOL         = 8'h03;
	localparam logic [7:0]  OFS_CPU         = 8'h04;
	localparam logic [7:0]  OFS_FILT        = 8'h05;
	localparam logic [7:0]  OFS_GAIN        = 8'h06;
	localparam logic [7:0]  OFS_MODE        = 8'h07;
	localparam logic [7:0]  OFS_SYNC        = 8'h08;
	localparam logic [7:0]  OFS_STATUS      = 8'h09;
	localparam logic [7:0]  OFS_HOME        = 8'h0A;
	localparam logic [7:0]  OFS_CORR        = 8'h0B;
	localparam logic [7:0]  OFS_STEP_BASE   = 8'h10;
	localparam logic [7:0]  OFS_PRESET_BASE = 8'h20;
	localparam logic [12:0] SEEK_FREQ_RST   = 13'h0064;
	localparam logic [12:0] SEEK_FREQ_MIN   = 13'h0001;
	localparam logic [12:0] SEEK_FREQ_MAX   = 13'h1388;
	localparam logic [15:0] TOL_RST         = 16'h0064;
	localparam logic [15:0] TOL_MIN         = 16'h0001;
	localparam logic [15:0] TOL_MAX         = 16'hC350;
	localparam logic [14:0] CPU_RST         = 15'h1000;
	localparam logic [14:0] CPU_MIN         = 15'h0001;
	localparam logic [14:0] CPU_MAX         = 15'h7D00;
	localparam logic [16:0] WHOLE_MAX       = 17'h0FA00;
	localparam logic [6:0]  FRAC_MAX        = 7'h63;
	localparam logic [6:0]  FRAC_DIV        = 7'h64;
	localparam logic [3:0]  FILT_RST        = 4'h8;
	localparam logic [10:0] GAIN_RST        = 11'h01E;
	localparam logic [10:0] GAIN_MAX        = 11'h7D0;
	localparam logic [2:0]  MODE_MAX        = 3'h4;
	localparam logic [14:0] SYNC_MAX        = 15'h7D00;
	localparam int          CMD_HOME_LIMIT  = 0;
	localparam int          CMD_FIND_HOME   = 1;
	localparam int          CMD_HOLD_STEP   = 2;
	localparam int          CMD_REDEFINE    = 3;
	localparam int          CMD_SYNC        = 4;
	localparam int          CMD_TRAV_DIS    = 5;
	localparam int          CMD_LOGIC1      = 6;
	localparam int          CMD_LOGIC2      = 7;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          SYNC_UNIT_NS    = 100000000;
	localparam int          FREQ_FULL_SCALE = 5000;
	localparam int          RAMP_UNIT_CYC   = SYNC_UNIT_NS / CLK_PERIOD_NS / FREQ_FULL_SCALE;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_HOME = 2'b10
	} sphc_state_e;

	typedef enum logic [2:0] {
		TM_TIMED     = 3'b000,
		TM_PRESET    = 3'b001,
		TM_LOGIC     = 3'b010,
		TM_PRESET_LG = 3'b011,
		TM_RESUME    = 3'b100
	} sphc_mode_e;

	typedef struct packed {
		logic [12:0] freq;
		logic        reverse;
		logic        accel2;
		logic [2:0]  step;
	} sphc_motion_s;
endpackage : sphc_pkg

// [sphc_step_pos_home.sv]
// Step positioning and homing logic: step select, target windows, homing, command word.
// Assumes synchronous inputs, encoder count already accumulated elsewhere.
//
// Overview of operation
// - Homing frequency limited to programmable maximum, 0.1..500.0 Hz, default 10.0.
// - Homing direction 0 forward, 1 reverse; changed only while stopped.
// - Position and home hits when encoder within target plus/minus tolerance.
// - Counts per user unit factor, default 4096, range 1..32000.
// - Eight step targets, whole units 0..64000, default 0.
// - Each step target also has hundredths 0..99, default 0.
// - Inputs one, two, three form step index LSB to MSB.
// - Second acceleration set when input two high, else first set.
// - Alternate acceleration input overrides the table choice.
// - Position error filter setting 0..15, default 8.
// - Position loop gain 0.0..200.0, default 3.0.
// - Eight-bit command word resets to zero, bits act as inputs.
// - Command bit 0 acts as the home limit switch, ORed with home_limit_pin.
// - Command bit 1 makes next start run homing.
// - Command bit 2 holds current step, zero speed once reached.
// - Command bit 3 sets home reference to current position.
// - Command bit 4 holds frequency while running when sync time is nonzero; release ramps at a rate of full scale per sync time.
// - Command bit 5 disables traverse modulation.
// - Command bits 6 and 7 ORed with step logic inputs.
// - Five transition modes 0..4 select step sequencing.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sphc_step_pos_home
	import sphc_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic [DATA_W-1:0]  reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [DATA_W-1:0]  reg_rdata,
	input  wire logic [2:0]         step_sel_in,
	input  wire logic               accel2_in,
	input  wire logic               logic_in1_pin,
	input  wire logic               logic_in2_pin,
	input  wire logic               home_limit_pin,
	input  wire logic               start_cmd,
	input  wire logic               stop_cmd,
	input  wire logic signed [31:0] encoder_count,
	output sphc_motion_s            motion,
	output logic                    target_window_hit,
	output logic                    origin_window_hit,
	output logic                    homing_active,
	output logic                    traverse_enable,
	output logic                    step_logic1,
	output logic                    step_logic2,
	output logic signed [31:0]      pos_correction
);
	////////////////////////////////////////////////////////////////////////////
	logic [7:0]         positioning_command_word;
	logic [12:0]        origin_seek_max_freq;
	logic               origin_seek_direction;
	logic [15:0]        position_tolerance;
	logic [14:0]        counts_per_user_unit;
	logic [3:0]         pos_error_filter;
	logic [10:0]        pos_loop_gain;
	logic [2:0]         transition_mode_select;
	logic [14:0]        sync_ramp_time;
	logic [16:0]        step_target_whole [8];
	logic [6:0]         step_target_frac [8];
	logic [12:0]        preset_freq [8];
	logic signed [31:0] home_ref;
	sphc_state_e        state;
	logic [2:0]         step_idx;
	logic               logic1_q;
	logic               logic2_q;
	logic               sync_q;
	logic               ramping;
	logic [26:0]        ramp_cnt;
	logic signed [31:0] err_filt;
	logic [12:0]        freq_target;
	logic [12:0]        freq_out;
	logic               home_limit;
	logic               hold_step;
	logic               sync_hold;
	logic signed [39:0] target_count;
	logic signed [39:0] target_diff;
	logic signed [39:0] home_diff;
	logic [31:0]        prod_whole;
	logic [21:0]        prod_frac;

	////////////////////////////////////////////////////////////////////////////
	// Register writes with range clamping
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			positioning_command_word <= 8'h00;
			origin_seek_max_freq     <= SEEK_FREQ_RST;
			origin_seek_direction    <= 1'b0;
			position_tolerance       <= TOL_RST;
			counts_per_user_unit     <= CPU_RST;
			pos_error_filter         <= FILT_RST;
			pos_loop_gain            <= GAIN_RST;
			transition_mode_select   <= 3'h0;
			sync_ramp_time           <= 15'h0000;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				OFS_CMD: positioning_command_word <= reg_wdata[7:0];
				OFS_SEEK_FREQ:
					origin_seek_max_freq <= (reg_wdata < 32'(SEEK_FREQ_MIN)) ? SEEK_FREQ_MIN :
						(reg_wdata > 32'(SEEK_FREQ_MAX)) ? SEEK_FREQ_MAX : reg_wdata[12:0];
				OFS_SEEK_DIR:
					if (state == ST_IDLE)
						origin_seek_direction <= reg_wdata[0];
				OFS_TOL:
					position_tolerance <= (reg_wdata < 32'(TOL_MIN)) ? TOL_MIN :
						(reg_wdata > 32'(TOL_MAX)) ? TOL_MAX : reg_wdata[15:0];
				OFS_CPU:
					counts_per_user_unit <= (reg_wdata < 32'(CPU_MIN)) ? CPU_MIN :
						(reg_wdata > 32'(CPU_MAX)) ? CPU_MAX : reg_wdata[14:0];
				OFS_FILT: pos_error_filter <= reg_wdata[3:0];
				OFS_GAIN:
					pos_loop_gain <= (reg_wdata > 32'(GAIN_MAX)) ? GAIN_MAX : reg_wdata[10:0];
				OFS_MODE:
					if (state == ST_IDLE && reg_wdata <= 32'(MODE_MAX))
						transition_mode_select <= reg_wdata[2:0];
				OFS_SYNC:
					sync_ramp_time <= (reg_wdata > 32'(SYNC_MAX)) ? SYNC_MAX : reg_wdata[14:0];
				default: ;
			endcase
		end
	end

	// Step tables and frequency presets
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < 8; i++)
			begin
				step_target_whole[i] <= 17'h00000;
				step_target_frac[i]  <= 7'h00;
				preset_freq[i]       <= 13'h0000;
			end
		end
		else if (reg_wr && reg_addr[7:4] == OFS_STEP_BASE[7:4])
		begin
			if (!reg_addr[0])
				step_target_whole[reg_addr[3:1]] <= (reg_wdata > 32'(WHOLE_MAX)) ?
					WHOLE_MAX : reg_wdata[16:0];
			else
				step_target_frac[reg_addr[3:1]] <= (reg_wdata > 32'(FRAC_MAX)) ?
					FRAC_MAX : reg_wdata[6:0];
		end
		else if (reg_wr && reg_addr[7:3] == OFS_PRESET_BASE[7:3])
			preset_freq[reg_addr[2:0]] <= (reg_wdata > 32'(SEEK_FREQ_MAX)) ?
				SEEK_FREQ_MAX : reg_wdata[12:0];
	end

	// Read port, data one cycle after the strobe, zero for unmapped
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			reg_rdata <= 32'h00000000;
			case (reg_addr)
				OFS_CMD:       reg_rdata <= {24'h000000, positioning_command_word};
				OFS_SEEK_FREQ: reg_rdata <= {19'h00000, origin_seek_max_freq};
				OFS_SEEK_DIR:  reg_rdata <= {31'h00000000, origin_seek_direction};
				OFS_TOL:       reg_rdata <= {16'h0000, position_tolerance};
				OFS_CPU:       reg_rdata <= {17'h00000, counts_per_user_unit};
				OFS_FILT:      reg_rdata <= {28'h0000000, pos_error_filter};
				OFS_GAIN:      reg_rdata <= {21'h000000, pos_loop_gain};
				OFS_MODE:      reg_rdata <= {29'h00000000, transition_mode_select};
				OFS_SYNC:      reg_rdata <= {17'h00000, sync_ramp_time};
				OFS_STATUS:    reg_rdata <= {6'h00, freq_out, 4'h0, ramping, step_idx,
					state, homing_active, origin_window_hit, target_window_hit};
				OFS_HOME:      reg_rdata <= home_ref;
				OFS_CORR:      reg_rdata <= pos_correction;
				default:
				begin
					if (reg_addr[7:4] == OFS_STEP_BASE[7:4])
						reg_rdata <= reg_addr[0] ? {25'h0000000, step_target_frac[reg_addr[3:1]]}
							: {15'h0000, step_target_whole[reg_addr[3:1]]};
					else if (reg_addr[7:3] == OFS_PRESET_BASE[7:3])
						reg_rdata <= {19'h00000, preset_freq[reg_addr[2:0]]};
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command word as input functions
	assign home_limit      = positioning_command_word[CMD_HOME_LIMIT] | home_limit_pin;
	assign hold_step       = positioning_command_word[CMD_HOLD_STEP];
	assign sync_hold       = positioning_command_word[CMD_SYNC] && (sync_ramp_time != 15'h0000);
	assign traverse_enable = !positioning_command_word[CMD_TRAV_DIS];
	assign step_logic1     = logic_in1_pin | positioning_command_word[CMD_LOGIC1];
	assign step_logic2     = logic_in2_pin | positioning_command_word[CMD_LOGIC2];
	assign homing_active   = (state == ST_HOME);

	// Target count and windows, evaluated every cycle
	always_comb
	begin
		prod_whole   = 32'({15'h0000, step_target_whole[step_idx]} * {17'h00000, counts_per_user_unit});
		prod_frac    = 22'({15'h0000, step_target_frac[step_idx]} * {7'h00, counts_per_user_unit})
			/ 22'(FRAC_DIV);
		target_count = 40'(home_ref) + $signed({8'h00, prod_whole})
			+ $signed({18'h00000, prod_frac});
		target_diff  = 40'(encoder_count) - target_count;
		home_diff    = 40'(encoder_count) - 40'(home_ref);
	end

	assign target_window_hit = (target_diff <= $signed({24'h000000, position_tolerance}))
		&& (target_diff >= -$signed({24'h000000, position_tolerance}));
	assign origin_window_hit = (home_diff <= $signed({24'h000000, position_tolerance}))
		&& (home_diff >= -$signed({24'h000000, position_tolerance}));

	////////////////////////////////////////////////////////////////////////////
	// Run, homing and step sequencing
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			logic1_q <= 1'b0;
			logic2_q <= 1'b0;
		end
		else
		begin
			logic1_q <= step_logic1;
			logic2_q <= step_logic2;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state    <= ST_IDLE;
			step_idx <= 3'h0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (start_cmd && positioning_command_word[CMD_FIND_HOME])
						state <= ST_HOME;
					else if (start_cmd)
					begin
						state <= ST_RUN;
						case (transition_mode_select)
							TM_PRESET, TM_PRESET_LG: step_idx <= step_sel_in;
							TM_RESUME:               step_idx <= step_idx;
							default:                 step_idx <= 3'h0;
						endcase
					end
				end
				ST_RUN:
				begin
					if (stop_cmd)
						state <= ST_IDLE;
					else if (!hold_step)
					begin
						case (transition_mode_select)
							TM_TIMED:
								if (target_window_hit)
									step_idx <= step_idx + 3'h1;
							TM_PRESET: step_idx <= step_sel_in;
							default:
								if (step_logic1 && !logic1_q)
									step_idx <= step_idx + 3'h1;
								else if (step_logic2 && !logic2_q)
									step_idx <= step_idx - 3'h1;
						endcase
					end
				end
				ST_HOME:
					if (stop_cmd || home_limit)
						state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Home reference: redefine bit or home limit while homing catches the encoder
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			home_ref <= 32'sh00000000;
		else if (positioning_command_word[CMD_REDEFINE])
			home_ref <= encoder_count;
		else if (state == ST_HOME && home_limit)
			home_ref <= encoder_count;
	end

	////////////////////////////////////////////////////////////////////////////
	// Frequency command with hold, sync hold and sync ramp
	always_comb
	begin
		case (state)
			ST_RUN:  freq_target = (hold_step && target_window_hit) ? 13'h0000
				: preset_freq[step_idx];
			ST_HOME: freq_target = origin_seek_max_freq;
			default: freq_target = 13'h0000;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			sync_q <= 1'b0;
		else
			sync_q <= sync_hold;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			freq_out <= 13'h0000;
			ramping  <= 1'b0;
			ramp_cnt <= 27'h0000000;
		end
		else if (state == ST_IDLE)
		begin
			freq_out <= 13'h0000;
			ramping  <= 1'b0;
			ramp_cnt <= 27'h0000000;
		end
		else if (state == ST_HOME)
		begin
			freq_out <= origin_seek_max_freq;
			ramping  <= 1'b0;
		end
		else if (sync_hold)
			freq_out <= freq_out;
		else if (sync_q || ramping)
		begin
			ramping <= (freq_out != freq_target);
			if (ramp_cnt >= 27'(32'(sync_ramp_time) * RAMP_UNIT_CYC))
			begin
				ramp_cnt <= 27'h0000000;
				if (freq_out < freq_target)
					freq_out <= freq_out + 13'h0001;
				else if (freq_out > freq_target)
					freq_out <= freq_out - 13'h0001;
			end
			else
				ramp_cnt <= ramp_cnt + 27'h0000001;
		end
		else
			freq_out <= freq_target;
	end

	always_comb
	begin
		motion.freq    = freq_out;
		motion.reverse = homing_active ? origin_seek_direction
			: (target_diff > 40'sh0000000000);
		motion.accel2  = accel2_in | step_sel_in[1];
		motion.step    = step_idx;
	end

	////////////////////////////////////////////////////////////////////////////
	// Position regulator: IIR error filter then gain in tenths
	logic signed [31:0] pos_err;
	logic signed [43:0] corr_full;

	assign pos_err   = 32'(-target_diff);
	assign corr_full = (44'(err_filt) * $signed({33'h000000000, pos_loop_gain})) / 44'sd10;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			err_filt       <= 32'sh00000000;
			pos_correction <= 32'sh00000000;
		end
		else
		begin
			err_filt       <= err_filt + ((pos_err - err_filt) >>> pos_error_filter);
			pos_correction <= 32'(corr_full);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	property p_cmd_reset;
		@(posedge ref_clk) rst |=> positioning_command_word == 8'h00;
	endproperty
	a_cmd_reset: assert property (p_cmd_reset) else $error("command word not cleared");

	property p_home_start;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_IDLE && start_cmd && positioning_command_word[CMD_FIND_HOME])
			|=> homing_active;
	endproperty
	a_home_start: assert property (p_home_start) else $error("homing not started");

	property p_home_freq;
		@(posedge ref_clk) disable iff (rst)
		homing_active ##1 homing_active |-> motion.freq == $past(origin_seek_max_freq);
	endproperty
	a_home_freq: assert property (p_home_freq) else $error("homing freq wrong");

	property p_accel;
		@(posedge ref_clk) disable iff (rst)
		motion.accel2 == (accel2_in || (step_sel_in inside {3'h2, 3'h3, 3'h6, 3'h7}));
	endproperty
	a_accel: assert property (p_accel) else $error("accel set wrong");

	property p_logic_or;
		@(posedge ref_clk) disable iff (rst)
		positioning_command_word[CMD_LOGIC1] |-> step_logic1;
	endproperty
	a_logic_or: assert property (p_logic_or) else $error("logic 1 not ORed");

	property p_hold_zero;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_RUN && hold_step && target_window_hit && !sync_hold && !sync_q
			&& !ramping && !stop_cmd) |=> (motion.freq == 13'h0000);
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("hold step not zero");

	property p_hold_step;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_RUN && hold_step && !stop_cmd) |=> $stable(step_idx);
	endproperty
	a_hold_step: assert property (p_hold_step) else $error("step moved under hold");

	property p_redefine;
		@(posedge ref_clk) disable iff (rst)
		positioning_command_word[CMD_REDEFINE] |=> home_ref == $past(encoder_count);
	endproperty
	a_redefine: assert property (p_redefine) else $error("home not redefined");

	property p_sync_hold;
		@(posedge ref_clk) disable iff (rst)
		(state == ST_RUN && sync_hold) ##1 (state == ST_RUN) |-> $stable(freq_out);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync hold moved freq");

	property p_window;
		@(posedge ref_clk) disable iff (rst)
		(encoder_count == 32'(target_count)) && (target_count[39:31] == 9'h000)
			|-> target_window_hit;
	endproperty
	a_window: assert property (p_window) else $error("exact target not a hit");

endmodule : sphc_step_pos_home
`default_nettype wire

// [sphc_enc_model.sv]
// Behavioural shaft encoder with a home limit switch.
// Assumes the motion command of the block and one clock; a load port places the shaft.
`timescale 1ns/1ps
`default_nettype none
module sphc_enc_model
	import sphc_pkg::*;
#(
	parameter logic signed [31:0] HOME_POS = 32'sh000004D2
)(
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire sphc_motion_s       motion,
	input  wire logic               load,
	input  wire logic signed [31:0] load_val,
	output logic signed [31:0]      encoder_count,
	output logic                    home_limit_pin
);
	// Shaft moves one count per cycle while the drive commands a frequency
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			encoder_count <= 32'sh00000000;
		else if (load)
			encoder_count <= load_val;
		else if (motion.freq != 13'h0000)
			encoder_count <= motion.reverse ? encoder_count - 1 : encoder_count + 1;
	end

	assign home_limit_pin = (encoder_count == HOME_POS);
endmodule : sphc_enc_model
`default_nettype wire

// [sphc_step_pos_home_tb.sv]
// Self-checking bench of the step positioning and homing block.
// Assumes the encoder model beside it and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sphc_step_pos_home_tb;
	import sphc_pkg::*;
	logic               ref_clk = 1'b0;
	logic               rst = 1'b1;
	logic [ADDR_W-1:0]  reg_addr = 8'h00;
	logic [DATA_W-1:0]  reg_wdata = 32'h00000000;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [DATA_W-1:0]  reg_rdata;
	logic [2:0]         step_sel_in = 3'h0;
	logic               accel2_in = 1'b0;
	logic               logic_in1_pin = 1'b0;
	logic               logic_in2_pin = 1'b0;
	logic               home_limit_pin;
	logic               start_cmd = 1'b0;
	logic               stop_cmd = 1'b0;
	logic signed [31:0] encoder_count;
	logic               enc_load = 1'b1;
	logic signed [31:0] enc_val = 32'sh00000000;
	sphc_motion_s       motion;
	logic               target_window_hit;
	logic               origin_window_hit;
	logic               homing_active;
	logic               traverse_enable;
	logic               step_logic1;
	logic               step_logic2;
	logic signed [31:0] pos_correction;
	int                 failures = 0;
	int                 n_checks = 0;
	int                 cycles = 0;

	always #5 ref_clk = ~ref_clk;

	sphc_step_pos_home dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.step_sel_in(step_sel_in), .accel2_in(accel2_in), .logic_in1_pin(logic_in1_pin),
		.logic_in2_pin(logic_in2_pin), .home_limit_pin(home_limit_pin),
		.start_cmd(start_cmd), .stop_cmd(stop_cmd), .encoder_count(encoder_count),
		.motion(motion), .target_window_hit(target_window_hit),
		.origin_window_hit(origin_window_hit), .homing_active(homing_active),
		.traverse_enable(traverse_enable), .step_logic1(step_logic1),
		.step_logic2(step_logic2), .pos_correction(pos_correction));

	sphc_enc_model enc (.ref_clk(ref_clk), .rst(rst), .motion(motion), .load(enc_load),
		.load_val(enc_val), .encoder_count(encoder_count), .home_limit_pin(home_limit_pin));

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rc

	task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		wr(a, d);
		rc(a, e);
	endtask : wc

	// Pulse start when s is high, else stop
	task automatic go(input logic s);
		@(posedge ref_clk);
		start_cmd <= s;
		stop_cmd  <= ~s;
		@(posedge ref_clk);
		start_cmd <= 1'b0;
		stop_cmd  <= 1'b0;
	endtask : go

	task automatic enc_at(input logic signed [31:0] v);
		@(posedge ref_clk);
		enc_load <= 1'b1;
		enc_val  <= v;
		tk(2);
	endtask : enc_at

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		rc(OFS_SEEK_FREQ, 32'h00000064);
		rc(OFS_SEEK_DIR, 32'h00000000);
		rc(OFS_TOL, 32'h00000064);
		rc(OFS_CPU, 32'h00001000);
		rc(OFS_STEP_BASE + 8'h0E, 32'h00000000);
		rc(OFS_STEP_BASE + 8'h0F, 32'h00000000);
		rc(OFS_FILT, 32'h00000008);
		rc(OFS_GAIN, 32'h0000001E);
		rc(OFS_CMD, 32'h00000000);
		rc(OFS_MODE, 32'h00000000);
		rc(8'hFF, 32'h00000000);
		wc(OFS_SEEK_FREQ, 32'h00000000, 32'h00000001);
		wc(OFS_SEEK_FREQ, 32'h00001FFF, 32'h00001388);
		wc(OFS_TOL, 32'h00000000, 32'h00000001);
		wc(OFS_TOL, 32'h0000FFFF, 32'h0000C350);
		wc(OFS_CPU, 32'h00000000, 32'h00000001);
		wc(OFS_CPU, 32'h00007FFF, 32'h00007D00);
		wc(OFS_STEP_BASE, 32'h00020000, 32'h0000FA00);
		wc(OFS_STEP_BASE + 8'h01, 32'h0000007F, 32'h00000063);
		wc(OFS_GAIN, 32'h000007FF, 32'h000007D0);
		wc(OFS_FILT, 32'h0000000F, 32'h0000000F);
		wc(OFS_MODE, 32'h00000005, 32'h00000000);
		wc(OFS_CMD, 32'h000000FF, 32'h000000FF);
		chk(32'({step_logic1, step_logic2, traverse_enable}), 32'h00000006);
		wr(OFS_CMD, 32'h00000000);
		tk(1);
		chk(32'({step_logic1, step_logic2, traverse_enable}), 32'h00000001);
		// Targets (i+1)*100 + i with 100 counts per unit, window of 5
		wr(OFS_CPU, 32'h00000064);
		wr(OFS_TOL, 32'h00000005);
		wr(OFS_FILT, 32'h00000000);
		wr(OFS_GAIN, 32'h00000014);
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_STEP_BASE + 8'(2 * i), 32'(i + 1));
			wr(OFS_STEP_BASE + 8'(2 * i + 1), 32'(i));
			wr(OFS_PRESET_BASE + 8'(i), 32'(16 + i));
		end
		wr(OFS_MODE, 32'h00000001);
		go(1'b1);
		for (int i = 0; i < 8; i++)
		begin
			step_sel_in <= 3'(i);
			accel2_in   <= 1'b0;
			enc_at(32'((i + 1) * 100 + i + 5));
			chk(32'(motion.step), 32'(i));
			chk(32'(motion.freq), 32'(16 + i));
			chk(32'(motion.accel2), 32'(i / 2 % 2));
			chk(32'(target_window_hit), 32'h00000001);
			accel2_in <= 1'b1;
			enc_at(32'((i + 1) * 100 + i - 6));
			chk(32'(motion.accel2), 32'h00000001);
			chk(32'(target_window_hit), 32'h00000000);
		end
		tk(1);
		chk(pos_correction, 32'h0000000C);
		// Sync hold keeps the old preset, slow ramp after release
		wr(OFS_SYNC, 32'h00000001);
		wr(OFS_CMD, 32'h00000010);
		step_sel_in <= 3'h0;
		tk(3);
		chk(32'(motion.freq), 32'h00000017);
		wr(OFS_CMD, 32'h00000000);
		tk(3);
		chk(32'(motion.freq), 32'h00000017);
		wr(OFS_SYNC, 32'h00000000);
		tk(12);
		chk(32'(motion.freq), 32'h00000010);
		step_sel_in <= 3'h7;
		enc_at(32'sh00000327);
		wr(OFS_CMD, 32'h00000004);
		step_sel_in <= 3'h2;
		tk(4);
		chk(32'(motion.step), 32'h00000007);
		chk(32'(motion.freq), 32'h00000000);
		wr(OFS_CMD, 32'h00000000);
		go(1'b0);
		wr(OFS_MODE, 32'h00000002);
		go(1'b1);
		tk(2);
		chk(32'(motion.step), 32'h00000000);
		wr(OFS_CMD, 32'h00000040);
		wr(OFS_CMD, 32'h00000000);
		tk(2);
		chk(32'(motion.step), 32'h00000001);
		go(1'b0);
		wr(OFS_MODE, 32'h00000004);
		go(1'b1);
		tk(2);
		chk(32'(motion.step), 32'h00000001);
		go(1'b0);
		wr(OFS_MODE, 32'h00000003);
		step_sel_in <= 3'h5;
		go(1'b1);
		tk(2);
		chk(32'(motion.step), 32'h00000005);
		logic_in2_pin <= 1'b1;
		tk(3);
		chk(32'(motion.step), 32'h00000004);
		logic_in2_pin <= 1'b0;
		go(1'b0);
		// Homing reverse from 1300 down to the switch at 1234
		wc(OFS_SEEK_DIR, 32'h00000001, 32'h00000001);
		wr(OFS_SEEK_FREQ, 32'h00000032);
		wr(OFS_CMD, 32'h00000002);
		enc_at(32'sh00000514);
		enc_load <= 1'b0;
		go(1'b1);
		tk(2);
		chk(32'({homing_active, motion.reverse}), 32'h00000003);
		chk(32'(motion.freq), 32'h00000032);
		wc(OFS_SEEK_DIR, 32'h00000000, 32'h00000001);
		for (int k = 0; k < 300 && homing_active !== 1'b0; k++)
			tk(1);
		rc(OFS_HOME, 32'h000004D2);
		chk(32'(origin_window_hit), 32'h00000001);
		wr(OFS_CMD, 32'h00000000);
		wr(OFS_CMD, 32'h00000002);
		enc_at(32'sh00000400);
		go(1'b1);
		tk(2);
		chk(32'(homing_active), 32'h00000001);
		wr(OFS_CMD, 32'h00000003);
		tk(3);
		chk(32'(homing_active), 32'h00000000);
		rc(OFS_HOME, 32'h00000400);
		wr(OFS_CMD, 32'h00000000);
		enc_at(32'sh00000309);
		wr(OFS_CMD, 32'h00000008);
		tk(2);
		rc(OFS_HOME, 32'h00000309);
		wr(OFS_CMD, 32'h00000000);
		wr(OFS_MODE, 32'h00000000);
		go(1'b1);
		tk(2);
		chk(32'(homing_active), 32'h00000000);
		enc_at(32'sh0000036D);
		chk(32'(motion.step), 32'h00000001);
		go(1'b0);
		conclude();
	end
endmodule : sphc_step_pos_home_tb
`default_nettype wire
